/* File: chp_pkg.sv */
`default_nettype none
package chp_pkg;
	localparam int CHP_W = 32;
	typedef logic [CHP_W-1:0] chp_word_t;
	// instruction fields
	localparam int CHP_CLASS_BIT = 27;
	localparam int CHP_XFER_BIT = 25;
	localparam int CHP_CREG_BIT = 4;
	localparam int CHP_LOAD_BIT = 20;
	localparam int CHP_NUM_LSB = 8;
	localparam int CHP_NUM_W = 4;
	localparam int CHP_CNT_LSB = 0;
	localparam int CHP_CNT_W = 4;
	// word counter, one bit wider than the count field
	localparam int CHP_WCNT_W = CHP_CNT_W + 1;
	localparam logic [CHP_WCNT_W-1:0] CHP_WCNT_ZERO = 5'h00;
	localparam logic [CHP_WCNT_W-1:0] CHP_ONE_WORD = 5'h01;
	localparam logic [CHP_WCNT_W-1:0] CHP_TWO_WORDS = 5'h02;
	localparam chp_word_t CHP_WORD_STEP = 32'h0000_0004;
	// handshake line levels
	localparam logic CHP_LINE_IDLE = 1'h1;
	localparam logic CHP_LINE_ACTIVE = 1'h0;
	// {mem_request_n, sequential_flag}
	localparam logic [1:0] CHP_CYC_N = 2'h0;
	localparam logic [1:0] CHP_CYC_S = 2'h1;
	localparam logic [1:0] CHP_CYC_I = 2'h2;
	localparam logic [1:0] CHP_CYC_C = 2'h3;
	// receive buffer
	localparam int CHP_FIFO_DEPTH = 2;
	localparam int CHP_FIFO_AW = 1;
	localparam logic [1:0] CHP_FIFO_EMPTY = 2'h0;
	localparam logic [1:0] CHP_FIFO_FULL = 2'h2;
	localparam logic [CHP_FIFO_AW-1:0] CHP_PTR_STEP = 1'h1;

	typedef enum logic [1:0] {
		CHP_CLS_UNDEF,
		CHP_CLS_CDP,
		CHP_CLS_CREG,
		CHP_CLS_CXFER
	} chp_class_t;

	function automatic chp_class_t chp_decode(input chp_word_t w);
		chp_class_t c;
		if (!w[CHP_CLASS_BIT])
			c = CHP_CLS_UNDEF;
		else if (!w[CHP_XFER_BIT])
			c = CHP_CLS_CXFER;
		else if (!w[CHP_CREG_BIT])
			c = CHP_CLS_CDP;
		else
			c = CHP_CLS_CREG;
		return c;
	endfunction : chp_decode
endpackage : chp_pkg
`default_nettype wire

/* File: chp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface chp_if;
	import chp_pkg::*;
	logic cop_instr_offer_n;
	logic cop_absent;
	logic cop_busy;
	logic opcode_fetch_n;
	logic mem_request_n;
	logic sequential_flag;
	logic user_mode_n;
	chp_word_t proc_addr;
	chp_word_t proc_d;
	logic proc_d_oe_n;
	chp_word_t cop_d;
	logic cop_d_oe_n;
	// driven by the memory system
	chp_word_t mem_d;
	logic data_bus_enable;
	logic cycle_hold_n;
	chp_word_t bus_d;

	// shared data bus level
	assign bus_d = !cop_d_oe_n ? cop_d : (!proc_d_oe_n ? proc_d : mem_d);

	modport proc (
		output cop_instr_offer_n, opcode_fetch_n, mem_request_n, sequential_flag,
		output user_mode_n, proc_addr, proc_d, proc_d_oe_n,
		input cop_absent, cop_busy, data_bus_enable, cycle_hold_n, bus_d
	);
	modport cop (
		output cop_absent, cop_busy, cop_d, cop_d_oe_n,
		input cop_instr_offer_n, opcode_fetch_n, mem_request_n, sequential_flag,
		input user_mode_n, proc_addr, data_bus_enable, cycle_hold_n, bus_d
	);
endinterface : chp_if
`default_nettype wire

/* File: chp_proc_end.sv */
`timescale 1ns/10ps
`default_nettype none
module chp_proc_end
	import chp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	chp_if.proc link,
	input wire logic start_in,
	input wire logic cond_pass_in,
	input wire logic user_mode_in,
	input wire logic irq_in,
	input wire logic irq_done_in,
	input wire chp_word_t addr_in,
	input wire chp_word_t wdata_in,
	output logic done_out,
	output logic undef_trap_out,
	output logic irq_taken_out,
	output chp_word_t rdata_out,
	output logic rdata_valid_out,
	output logic busy_out
);
	typedef enum logic [2:0] {
		CHP_P_IDLE,
		CHP_P_FETCH,
		CHP_P_OFFER,
		CHP_P_HS,
		CHP_P_IRQ,
		CHP_P_CREG,
		CHP_P_XFER
	} chp_pst_t;

	typedef struct packed {
		chp_pst_t st;
		chp_word_t instr;
		logic cond;
		chp_word_t addr;
		logic offer_n;
		logic opc_n;
		logic [1:0] cyc;
		logic umode_n;
		chp_word_t d;
		logic d_oe_n;
		logic done;
		logic trap;
		logic irqt;
		chp_word_t rdata;
		logic rvalid;
		logic busy;
	} chp_preg_t;

	localparam chp_preg_t CHP_P_RST = '{st: CHP_P_IDLE, offer_n: CHP_LINE_IDLE,
		opc_n: CHP_LINE_IDLE, cyc: CHP_CYC_I, umode_n: CHP_LINE_IDLE,
		d_oe_n: CHP_LINE_IDLE, default: '0};

	chp_preg_t r;
	chp_preg_t next_r;
	logic en;
	logic lines_low;
	logic lines_high;

	// RULE_21 hold acts as a stretched clock
	assign en = ce_in & link.cycle_hold_n;
	// RULE_06 sample all three lines
	assign lines_low = !link.cop_absent && !link.cop_busy && !r.offer_n;
	assign lines_high = link.cop_absent && link.cop_busy;

	always_comb
	begin
		next_r = r;
		next_r.done = 1'h0;
		next_r.trap = 1'h0;
		next_r.irqt = 1'h0;
		next_r.rvalid = 1'h0;
		next_r.d_oe_n = CHP_LINE_IDLE;
		next_r.umode_n = !user_mode_in;
		case (r.st)
			CHP_P_IDLE:
				if (start_in)
				begin
					next_r.opc_n = CHP_LINE_ACTIVE;
					next_r.cyc = CHP_CYC_N;
					next_r.cond = cond_pass_in;
					next_r.addr = addr_in;
					next_r.st = CHP_P_FETCH;
				end
			CHP_P_FETCH:
			begin
				next_r.instr = link.bus_d;
				next_r.opc_n = CHP_LINE_IDLE;
				next_r.cyc = CHP_CYC_I;
				// RULE_01 offer only if condition passes
				if (r.cond)
				begin
					next_r.offer_n = CHP_LINE_ACTIVE;
					next_r.st = CHP_P_OFFER;
				end
				else
				begin
					next_r.done = 1'h1;
					next_r.st = CHP_P_IDLE;
				end
			end
			CHP_P_OFFER:
				next_r.st = CHP_P_HS;
			CHP_P_HS:
				// RULE_06 commit when all low
				if (lines_low)
				begin
					next_r.offer_n = CHP_LINE_IDLE;
					case (chp_decode(r.instr))
						CHP_CLS_CDP:
						begin
							// RULE_20 data operation completes at once
							next_r.done = 1'h1;
							next_r.st = CHP_P_IDLE;
						end
						CHP_CLS_CREG:
						begin
							// RULE_13 register transfer cycle type
							next_r.cyc = CHP_CYC_C;
							if (!r.instr[CHP_LOAD_BIT])
							begin
								next_r.d = wdata_in;
								next_r.d_oe_n = link.data_bus_enable ? CHP_LINE_ACTIVE : CHP_LINE_IDLE;
							end
							next_r.st = CHP_P_CREG;
						end
						CHP_CLS_CXFER:
						begin
							next_r.cyc = CHP_CYC_S;
							next_r.st = CHP_P_XFER;
						end
						default:
						begin
							next_r.trap = 1'h1;
							next_r.st = CHP_P_IDLE;
						end
					endcase
				end
				// RULE_03 nobody answered, trap
				// RULE_19 undefined instructions trap here
				else if (lines_high)
				begin
					next_r.offer_n = CHP_LINE_IDLE;
					next_r.trap = 1'h1;
					next_r.st = CHP_P_IDLE;
				end
				// RULE_05 interrupt breaks busy wait
				else if (irq_in)
				begin
					next_r.offer_n = CHP_LINE_IDLE;
					next_r.irqt = 1'h1;
					next_r.st = CHP_P_IRQ;
				end
			CHP_P_IRQ:
				// RULE_17 re-offer from the start
				if (irq_done_in)
				begin
					next_r.offer_n = CHP_LINE_ACTIVE;
					next_r.st = CHP_P_OFFER;
				end
			CHP_P_CREG:
			begin
				if (r.instr[CHP_LOAD_BIT])
				begin
					next_r.rdata = link.bus_d;
					next_r.rvalid = 1'h1;
				end
				next_r.cyc = CHP_CYC_I;
				next_r.done = 1'h1;
				next_r.st = CHP_P_IDLE;
			end
			CHP_P_XFER:
			begin
				// RULE_11 one word per cycle
				next_r.addr = r.addr + CHP_WORD_STEP;
				if (lines_high)
				begin
					next_r.cyc = CHP_CYC_I;
					next_r.done = 1'h1;
					next_r.st = CHP_P_IDLE;
				end
			end
			default:
				next_r = CHP_P_RST;
		endcase
		next_r.busy = (next_r.st != CHP_P_IDLE);
	end

	// RULE_22 state held indefinitely while frozen
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			r <= CHP_P_RST;
		else if (en)
			r <= next_r;
	end

	assign link.cop_instr_offer_n = r.offer_n;
	assign link.opcode_fetch_n = r.opc_n;
	assign link.mem_request_n = r.cyc[1];
	assign link.sequential_flag = r.cyc[0];
	assign link.user_mode_n = r.umode_n;
	assign link.proc_addr = r.addr;
	assign link.proc_d = r.d;
	assign link.proc_d_oe_n = r.d_oe_n;
	assign done_out = r.done;
	assign undef_trap_out = r.trap;
	assign irq_taken_out = r.irqt;
	assign rdata_out = r.rdata;
	assign rdata_valid_out = r.rvalid;
	assign busy_out = r.busy;
endmodule : chp_proc_end
`default_nettype wire

/* File: chp_cop_end.sv */
// Contract
// RULE_01: processor offers executed coprocessor or undefined instructions
// RULE_02: matching coprocessor number pulls absent low
// RULE_03: absent and busy high means undefined trap
// RULE_04: only claiming coprocessor drops busy when ready
// RULE_05: processor busy-waits, interrupt abandons the handshake
// RULE_06: all three low at edge commits
// RULE_07: offer rising before commit discards instruction
// RULE_08: absent and busy high outside handshakes
// RULE_09: copy fetched words into own pipeline
// RULE_10: transfer at bus rate, drive only with enable
// RULE_11: address steps per word, both high ends
// RULE_12: at most sixteen words per transfer
// RULE_13: register transfer shown as request and sequential high
// RULE_14: memory raises bus enable when bus free
// RULE_15: restricted instructions appear absent in user mode
// RULE_16: nothing irreversible happens before going not-busy
// RULE_17: interrupted instruction is re-executed from start
// RULE_18: returned value follows not-busy by one cycle
// RULE_19: bit 27 clear means undefined, stay absent
// RULE_20: data operation completes immediately after not-busy
// RULE_21: cycle hold low acts like stretched clock
// RULE_22: sixteen coprocessors, hold state without time limit
`timescale 1ns/10ps
`default_nettype none
module chp_cop_end
	import chp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	chp_if.cop link,
	input wire logic [CHP_NUM_W-1:0] cop_num_in,
	input wire logic user_restrict_in,
	input wire logic ready_in,
	input wire chp_word_t supply_data_in,
	input wire logic rx_ready_in,
	output chp_word_t instr_out,
	output logic claim_out,
	output logic exec_out,
	output logic discard_out,
	output logic supply_take_out,
	output chp_word_t rx_data_out,
	output logic rx_valid_out
);
	typedef enum logic [1:0] {
		CHP_C_IDLE,
		CHP_C_CLAIM,
		CHP_C_XFER
	} chp_cst_t;

	typedef struct packed {
		chp_cst_t st;
		chp_word_t pipe;
		logic absent;
		logic busy;
		chp_word_t d;
		logic d_oe_n;
		logic into;
		logic [CHP_WCNT_W-1:0] cnt;
		logic [CHP_WCNT_W-1:0] want;
		logic exec;
		logic discard;
		logic take;
		logic claim;
		logic [CHP_FIFO_DEPTH-1:0][CHP_W-1:0] mem;
		logic [CHP_FIFO_AW-1:0] wp;
		logic [CHP_FIFO_AW-1:0] rp;
		logic [1:0] count;
		chp_word_t rx_data;
		logic rx_valid;
	} chp_creg_t;

	localparam chp_creg_t CHP_C_RST = '{st: CHP_C_IDLE, absent: CHP_LINE_IDLE,
		busy: CHP_LINE_IDLE, d_oe_n: CHP_LINE_IDLE, default: '0};

	chp_creg_t r;
	chp_creg_t next_r;
	logic en;
	chp_class_t cls;
	logic match;
	logic push;
	logic pop;
	logic [1:0] fill_after;
	logic final_next;
	logic load_word;
	logic ready_now;

	// RULE_21 hold freezes the whole end
	assign en = ce_in & link.cycle_hold_n;
	assign cls = chp_decode(r.pipe);
	// RULE_02 number match claims the instruction
	// RULE_19 undefined instructions never match
	// RULE_15 appear absent when restricted in user mode
	assign match = (cls != CHP_CLS_UNDEF)
		&& (r.pipe[CHP_NUM_LSB +: CHP_NUM_W] == cop_num_in)
		&& !(user_restrict_in && !link.user_mode_n);
	// RULE_04 busy drops only when able to finish
	assign ready_now = ready_in && (r.count == CHP_FIFO_EMPTY);
	assign push = (r.st == CHP_C_XFER) && r.into && (r.count != CHP_FIFO_FULL);
	assign pop = rx_ready_in && (r.count != CHP_FIFO_EMPTY);
	assign fill_after = r.count + {1'h0, push} - {1'h0, pop};

	always_comb
	begin
		next_r = r;
		final_next = 1'h0;
		load_word = 1'h0;
		next_r.exec = 1'h0;
		next_r.discard = 1'h0;
		next_r.take = 1'h0;
		next_r.d_oe_n = CHP_LINE_IDLE;
		// RULE_09 follow the instruction pipeline
		if (!link.opcode_fetch_n)
			next_r.pipe = link.bus_d;
		case (r.st)
			CHP_C_IDLE:
				if (!link.cop_instr_offer_n && match)
				begin
					next_r.absent = CHP_LINE_ACTIVE;
					next_r.busy = ready_now ? CHP_LINE_ACTIVE : CHP_LINE_IDLE;
					next_r.st = CHP_C_CLAIM;
				end
			CHP_C_CLAIM:
				// RULE_07 break-off discards the instruction
				if (link.cop_instr_offer_n)
				begin
					next_r.discard = 1'h1;
					next_r.absent = CHP_LINE_IDLE;
					next_r.busy = CHP_LINE_IDLE;
					next_r.st = CHP_C_IDLE;
				end
				// RULE_06 all three low commits
				else if (r.busy == CHP_LINE_ACTIVE)
				begin
					next_r.exec = 1'h1;
					next_r.cnt = CHP_WCNT_ZERO;
					// RULE_08 release lines unless more than one word follows
					next_r.absent = CHP_LINE_IDLE;
					next_r.busy = CHP_LINE_IDLE;
					next_r.st = CHP_C_IDLE;
					case (cls)
						CHP_CLS_CDP:
							// RULE_20 no transfer cycles follow
							next_r.st = CHP_C_IDLE;
						CHP_CLS_CREG:
						begin
							// RULE_13 single bus cycle after commit
							next_r.want = CHP_ONE_WORD;
							next_r.into = !r.pipe[CHP_LOAD_BIT];
							// RULE_18 value driven the next cycle
							load_word = r.pipe[CHP_LOAD_BIT];
							next_r.st = CHP_C_XFER;
						end
						CHP_CLS_CXFER:
						begin
							// RULE_12 count field caps at sixteen
							next_r.want = {1'h0, r.pipe[CHP_CNT_LSB +: CHP_CNT_W]} + CHP_ONE_WORD;
							next_r.into = r.pipe[CHP_LOAD_BIT];
							load_word = !r.pipe[CHP_LOAD_BIT];
							final_next = (next_r.want == CHP_ONE_WORD);
							next_r.absent = final_next ? CHP_LINE_IDLE : CHP_LINE_ACTIVE;
							next_r.busy = next_r.absent;
							next_r.st = CHP_C_XFER;
						end
						default:
							next_r.st = CHP_C_IDLE;
					endcase
				end
				// RULE_16 only the busy line changes here
				else
					next_r.busy = ready_now ? CHP_LINE_ACTIVE : CHP_LINE_IDLE;
			CHP_C_XFER:
			begin
				next_r.cnt = r.cnt + CHP_ONE_WORD;
				// RULE_11 both high marks the last word
				if (r.absent == CHP_LINE_IDLE)
					next_r.st = CHP_C_IDLE;
				else
				begin
					final_next = ((r.cnt + CHP_TWO_WORDS) == r.want)
						|| (r.into && (fill_after != CHP_FIFO_EMPTY));
					load_word = !r.into;
					next_r.absent = final_next ? CHP_LINE_IDLE : CHP_LINE_ACTIVE;
					next_r.busy = next_r.absent;
				end
			end
			default:
				next_r = CHP_C_RST;
		endcase
		// RULE_10 drive only while bus enable is high
		// RULE_14 relies on memory raising bus enable
		if (load_word)
		begin
			next_r.d = supply_data_in;
			next_r.d_oe_n = link.data_bus_enable ? CHP_LINE_ACTIVE : CHP_LINE_IDLE;
			next_r.take = 1'h1;
		end
		// receive buffer toward the user side
		if (push)
		begin
			next_r.mem[r.wp] = link.bus_d;
			next_r.wp = r.wp + CHP_PTR_STEP;
		end
		if (pop)
			next_r.rp = r.rp + CHP_PTR_STEP;
		next_r.count = fill_after;
		next_r.rx_valid = (next_r.count != CHP_FIFO_EMPTY);
		next_r.rx_data = next_r.mem[next_r.rp];
		next_r.claim = (next_r.st != CHP_C_IDLE);
	end

	// RULE_22 no limit on how long state is held
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			r <= CHP_C_RST;
		else if (en)
			r <= next_r;
	end

	assign link.cop_absent = r.absent;
	assign link.cop_busy = r.busy;
	assign link.cop_d = r.d;
	assign link.cop_d_oe_n = r.d_oe_n;
	assign instr_out = r.pipe;
	assign claim_out = r.claim;
	assign exec_out = r.exec;
	assign discard_out = r.discard;
	assign supply_take_out = r.take;
	assign rx_data_out = r.rx_data;
	assign rx_valid_out = r.rx_valid;
endmodule : chp_cop_end
`default_nettype wire

/* File: chp_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module chp_chk
	import chp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic cop_instr_offer_n,
	input wire logic cop_absent,
	input wire logic cop_busy,
	input wire logic mem_request_n,
	input wire logic sequential_flag,
	input wire logic proc_d_oe_n,
	input wire logic cop_d_oe_n,
	input wire logic data_bus_enable,
	input wire logic cycle_hold_n,
	input wire chp_word_t proc_addr
);
	logic [1:0] cyc;
	logic [5:0] s_run;
	assign cyc = {mem_request_n, sequential_flag};
	// run length of sequential cycles
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			s_run <= 6'h00;
		else if (cyc != CHP_CYC_S)
			s_run <= 6'h00;
		else if (cycle_hold_n && s_run != 6'h3F)
			s_run <= s_run + 6'h01;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	busy_needs_claim_a: assert property (!cop_busy |-> !cop_absent)
		else $error("busy low without claim");
	idle_lines_high_a: assert property (cop_instr_offer_n && $past(cop_instr_offer_n)
		&& $past(cycle_hold_n) && cyc == CHP_CYC_I |-> cop_absent && cop_busy)
		else $error("handshake lines not idle");
	dbe_gates_drive_a: assert property (!cop_d_oe_n |-> $past(data_bus_enable))
		else $error("bus driven without enable");
	creg_cycle_type_a: assert property (!proc_d_oe_n |-> cyc == CHP_CYC_C)
		else $error("register transfer not shown as C cycle");
	commit_releases_a: assert property (!cop_instr_offer_n && !cop_absent && !cop_busy
		&& cycle_hold_n |=> cop_instr_offer_n)
		else $error("offer kept after commit");
	absent_trap_a: assert property (!cop_instr_offer_n && !$past(cop_instr_offer_n)
		&& $past(cycle_hold_n) && cycle_hold_n && cop_absent && cop_busy |=> cop_instr_offer_n)
		else $error("no trap on absent");
	addr_step_a: assert property (cyc == CHP_CYC_S && $past(cyc) == CHP_CYC_S
		&& $past(cycle_hold_n) |-> proc_addr == $past(proc_addr) + CHP_WORD_STEP)
		else $error("address not stepped by a word");
	xfer_limit_a: assert property (s_run <= 6'h10)
		else $error("transfer longer than sixteen words");
	hold_freezes_a: assert property (!cycle_hold_n |=> $stable({cop_instr_offer_n,
		cop_absent, cop_busy, cyc, proc_d_oe_n, cop_d_oe_n, proc_addr}))
		else $error("lines moved during hold");
endmodule : chp_chk
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected %0t %s", $time, m); end end
module tb;
	import chp_pkg::*;
	localparam chp_word_t CDP = 32'h0E00_0500;
	localparam chp_word_t BASE = 32'h0000_1000;
	logic clk, rstn, start, cond, umode, irq, irq_done, rx_ready, ready, user_lock;
	chp_word_t ins, wdata, supply, rdata, instr, rx_data;
	logic done, trap, irq_taken, rdata_valid, pbusy, ex, discard, rx_valid, claim, take;
	int num_errors = 0;
	int checks_done = 0;
	chp_if bus();
	// memory returns the instruction on fetches, an address pattern otherwise
	assign bus.mem_d = !bus.opcode_fetch_n ? ins : ~bus.proc_addr;
	assign bus.data_bus_enable = 1'h1;
	chp_proc_end chp_proc_end_inst (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(1'h1),
		.link(bus.proc), .start_in(start), .cond_pass_in(cond), .user_mode_in(umode),
		.irq_in(irq), .irq_done_in(irq_done), .addr_in(BASE), .wdata_in(wdata),
		.done_out(done), .undef_trap_out(trap), .irq_taken_out(irq_taken),
		.rdata_out(rdata), .rdata_valid_out(rdata_valid), .busy_out(pbusy));
	chp_cop_end chp_cop_end_inst (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(1'h1),
		.link(bus.cop), .cop_num_in(4'h5), .user_restrict_in(user_lock), .ready_in(ready),
		.supply_data_in(supply), .rx_ready_in(rx_ready), .instr_out(instr), .claim_out(claim),
		.exec_out(ex), .discard_out(discard), .supply_take_out(take), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid));
	chp_chk chp_chk_inst (.sys_clk_in(clk), .rstn_in(rstn),
		.cop_instr_offer_n(bus.cop_instr_offer_n), .cop_absent(bus.cop_absent),
		.cop_busy(bus.cop_busy), .mem_request_n(bus.mem_request_n),
		.sequential_flag(bus.sequential_flag), .proc_d_oe_n(bus.proc_d_oe_n),
		.cop_d_oe_n(bus.cop_d_oe_n), .data_bus_enable(bus.data_bus_enable),
		.cycle_hold_n(bus.cycle_hold_n), .proc_addr(bus.proc_addr));

	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic conclude;
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
		end
	endtask : tick

	task automatic go(input chp_word_t i, input logic c);
		ins = i;
		cond = c;
		start = 1'h1;
		tick(1);
		start = 1'h0;
	endtask : go

	task automatic fin(output int n);
		n = 1;
		while (done !== 1'h1 && trap !== 1'h1 && n < 40)
		begin
			tick(1);
			n++;
		end
	endtask : fin

	task automatic pop(input chp_word_t e);
		`CHK(rx_data, e, "rx word")
		rx_ready = 1'h1;
		tick(1);
		rx_ready = 1'h0;
	endtask : pop

	task automatic one(input chp_word_t i, input logic c, u, input int en, input logic et);
		int n;
		umode = u;
		user_lock = u;
		go(i, c);
		fin(n);
		`CHK(n, en, "cycle count")
		`CHK(trap, et, "trap")
		`CHK(ex, c & !et, "commit seen")
		umode = 1'h0;
		user_lock = 1'h0;
		tick(1);
	endtask : one

	task automatic t_traps;
		one(CDP, 1'h1, 1'h0, 4, 1'h0);
		`CHK(instr, CDP, "pipeline copy")
		one(CDP, 1'h0, 1'h0, 2, 1'h0);
		one(32'h0600_0500, 1'h1, 1'h0, 4, 1'h1);
		one(32'h0E00_0700, 1'h1, 1'h0, 4, 1'h1);
		one(CDP, 1'h1, 1'h1, 4, 1'h1);
	endtask : t_traps

	task automatic t_busy_irq;
		int n;
		ready = 1'h0;
		go(CDP, 1'h1);
		tick(4);
		`CHK({bus.cop_absent, bus.cop_busy, pbusy, claim}, 4'h7, "busy wait")
		// hold moves only while the clock is low
		@(negedge clk);
		bus.cycle_hold_n = 1'h0;
		repeat (3) @(negedge clk);
		bus.cycle_hold_n = 1'h1;
		tick(1);
		irq = 1'h1;
		n = 0;
		while (irq_taken !== 1'h1 && n < 10)
		begin
			tick(1);
			n++;
		end
		irq = 1'h0;
		`CHK(irq_taken, 1'h1, "irq taken")
		`CHK(bus.cop_instr_offer_n, 1'h1, "offer withdrawn")
		tick(1);
		`CHK(discard, 1'h1, "discard")
		ready = 1'h1;
		irq_done = 1'h1;
		tick(1);
		irq_done = 1'h0;
		fin(n);
		`CHK({done, ex, trap}, 3'h6, "retry")
		tick(1);
	endtask : t_busy_irq

	task automatic t_mcr;
		int n;
		wdata = 32'hA5C3_0F1E;
		go(32'h0E00_0510, 1'h1);
		fin(n);
		`CHK(n, 5, "mcr length")
		`CHK(rx_valid, 1'h1, "mcr rx")
		pop(32'hA5C3_0F1E);
		`CHK(rx_valid, 1'h0, "rx empty")
	endtask : t_mcr

	task automatic t_mrc;
		int n;
		supply = 32'h1234_ABCD;
		go(32'h0E10_0510, 1'h1);
		// commit edge passed, word loaded for the next cycle
		tick(3);
		`CHK({ex, take, bus.cop_d_oe_n}, 3'h6, "mrc word driven")
		fin(n);
		`CHK(n, 2, "mrc length")
		`CHK({rdata_valid, rdata}, {1'h1, 32'h1234_ABCD}, "mrc data")
		tick(1);
	endtask : t_mrc

	task automatic t_ldc;
		int n;
		go(32'h0C10_0501, 1'h1);
		fin(n);
		`CHK(n, 6, "ldc length")
		pop(~BASE);
		pop(~(BASE + 32'h0000_0004));
		`CHK(rx_valid, 1'h0, "rx drained")
	endtask : t_ldc

	initial
	begin
		#200000;
		num_errors++;
		conclude();
	end

	initial
	begin
		rstn = 1'h0;
		start = 1'h0;
		cond = 1'h0;
		umode = 1'h0;
		irq = 1'h0;
		irq_done = 1'h0;
		rx_ready = 1'h0;
		ready = 1'h1;
		user_lock = 1'h0;
		ins = CDP;
		wdata = 32'h0000_0000;
		supply = 32'h0000_0000;
		bus.cycle_hold_n = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		rstn = 1'h1;
		t_traps();
		t_busy_irq();
		t_mcr();
		t_mrc();
		t_ldc();
		conclude();
	end
endmodule : tb
`default_nettype wire
